// ### hdl/standby_regulator_control.sv
// Standby regulator control: wait counter, regulator write guard, HALT and standby clock gating.
//
// Operation
// RL1 - Wait select codes 0 to 6 choose 2^(10+code) oscillator cycles; code 7 invalid.
// RL2 - Wait select register resets to 06H.
// RL3 - Wait applies after STOP release and after IDLE2 release.
// RL4 - After STOP release counting starts only once the oscillator runs.
// RL5 - Software writes zero to wait select bits 3 to 7.
// RL6 - Wait select register is accessed as a whole byte.
// RL7 - Regulator mode writes ignored unless guard register holds C9H.
// RL8 - Software writes only C9H or 00H to the guard register.
// RL9 - Guard register resets to 00H, the protected state.
// RL10 - Guard and regulator mode registers are accessed as whole bytes only.
// RL11 - Software keeps the guard at 00H except while changing regulator mode.
// RL12 - Regulator bit 1 lowers voltage in subclock modes, bit 0 in STOP.
// RL13 - Software writes only 00H, 01H or 02H to the regulator mode register.
// RL14 - Regulator mode resets to 00H and reads back written value freely.
// RL15 - Software stops main clock and PLL before low-voltage subclock selection.
// RL16 - HALT gates only the CPU clock; other clocks keep running.
// RL17 - Software places five no-operation instructions after the halt instruction.
// RL18 - Pending unmasked interrupt at halt enters then leaves HALT at once.
// RL19 - HALT released by non-maskable, unmasked interrupts or any reset source.
// RL20 - Software selects standby mode bits before setting the standby trigger.
// RL21 - Mode bits decode 00 IDLE1, x1 STOP, 10 IDLE2.
// RL22 - Wait counter restarts at each release and gates the CPU clock until done.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module standby_regulator_control #(
  parameter int cnt_width = 17
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [31:0]                    s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [31:0]                    s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic                           halt_exec,
  input  wire logic                           irq_pending,
  input  wire logic                           nmi_pin,
  input  wire logic                           watchdog_nonmaskable_irq,
  input  wire logic                           external_irq_pins,
  input  wire logic                           peripheral_irq,
  input  wire logic                           reset_source,
  input  wire logic                           osc_running,
  output logic                                cpu_clk_en,
  output logic                                periph_clk_en,
  output logic                                low_voltage_stop_sel,
  output logic                                low_voltage_subclock_sel,
  output logic                                halted,
  output logic                                waiting,
  output logic [standby_pkg::wait_sel_width-1:0] wait_sel_bits
);
  import standby_pkg::*;

  if (cnt_width < wait_max_exp + 1) begin : g_cnt_width_check
    $error("cnt_width too small for longest wait");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus slave.
  logic                aw_held_q;
  logic                w_held_q;
  logic [11:0]         aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic [7:0]          wait_sel_q;
  logic [7:0]          guard_q;
  logic [7:0]          lvs_q;
  logic [7:0]          mode_q;
  pwr_state_t          state_q;
  pwr_state_t          state_d;
  logic [cnt_width-1:0] cnt_q;
  logic                stop_pending_q;

  // The 0x332 map offset is only halfword aligned, so the regulator register answers on its containing word.
  function automatic logic [11:0] word_of(input logic [11:0] a);
    word_of = {a[11:2], 2'b00};
  endfunction

  wire        wr_fire   = aw_held_q && w_held_q && !bvalid_q;
  wire [11:0] wr_word   = word_of(aw_addr_q);
  wire [1:0]  lvs_lane  = reg_lvs_off[1:0];
  wire        full_wr   = (w_strb_q == 4'hf);
  wire        lvs_wr_ok = (w_strb_q[lvs_lane]) && (w_strb_q == (4'h1 << lvs_lane));
  wire        hit_lvs   = wr_word == word_of(reg_lvs_off);
  wire        hit_wait  = wr_word == reg_wait_off;
  wire        hit_guard = wr_word == reg_guard_off;
  wire        hit_mode  = wr_word == reg_mode_off;
  // The byte lane is chosen once both halves are held, so data may arrive before its address.
  wire [7:0]  wr_byte   = hit_lvs ? w_data_q[8*lvs_lane +: 8] : w_data_q[7:0];
  wire        wr_known  = hit_lvs || hit_wait || hit_guard || hit_mode;
  wire        wr_wait   = wr_fire && hit_wait && full_wr;  // [RL6]
  wire        wr_guard  = wr_fire && hit_guard && full_wr;  // [RL10]
  wire        wr_lvs    = wr_fire && hit_lvs && lvs_wr_ok && (guard_q == guard_enable);  // [RL7] [RL10]
  wire        wr_mode   = wr_fire && hit_mode && full_wr;
  wire        wr_bad    = !wr_known || (hit_lvs ? !lvs_wr_ok : !full_wr);

  wire [11:0] rd_word   = word_of(s_axi_araddr[11:0]);
  wire        rd_fire   = s_axi_arvalid && !rvalid_q;
  wire        rd_lvs    = rd_word == word_of(reg_lvs_off);
  wire        rd_known  = rd_lvs || rd_word == reg_wait_off || rd_word == reg_guard_off ||
                          rd_word == reg_mode_off || rd_word == reg_stat_off;
  wire [31:0] lvs_rd    = {24'h000000, lvs_q} << (8 * lvs_lane);  // [RL14]
  wire [31:0] stat_rd   = {28'h0000000, stop_pending_q, waiting, halted, cpu_clk_en};
  wire [31:0] rd_val    = rd_lvs ? lvs_rd :
                          rd_word == reg_wait_off  ? {24'h000000, wait_sel_q} :
                          rd_word == reg_guard_off ? {24'h000000, guard_q} :
                          rd_word == reg_mode_off  ? {24'h000000, mode_q} :
                          rd_word == reg_stat_off  ? stat_rd : 32'h00000000;

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= axi_okay;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_bad ? axi_slverr : axi_okay;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= axi_okay;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_known ? axi_okay : axi_slverr;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  // The trigger bit clears itself when standby is entered, so one write makes one entry.
  wire standby_enter = (state_q == st_run) && mode_q[mode_trig_bit] && !wr_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_sel_q <= wait_sel_reset;  // [RL2]
      guard_q    <= guard_reset;  // [RL9]
      lvs_q      <= lvs_reset;  // [RL14]
      mode_q     <= mode_reset;
    end else begin
      if (wr_wait) begin
        wait_sel_q <= wr_byte;  // [RL6]
      end
      if (wr_guard) begin
        guard_q <= wr_byte;  // [RL7]
      end
      if (wr_lvs) begin
        lvs_q <= wr_byte;  // [RL7] [RL14]
      end
      if (wr_mode) begin
        mode_q <= wr_byte;
      end else if (standby_enter) begin
        mode_q[mode_trig_bit] <= 1'b0;
      end
    end
  end

  assign low_voltage_stop_sel     = lvs_q[lvs_stop_bit];  // [RL12]
  assign low_voltage_subclock_sel = lvs_q[lvs_sub_bit];  // [RL12]
  assign wait_sel_bits            = wait_sel_q[wait_sel_width-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // HALT, standby and stabilisation wait.
  wire sel_stop  = mode_q[0];  // [RL21]
  wire sel_idle2 = mode_q[1:0] == 2'b10;  // [RL21]
  wire release_ev = nmi_pin || watchdog_nonmaskable_irq || external_irq_pins ||
                    peripheral_irq || irq_pending;  // [RL19]
  // Code 7 is not a valid choice; it is served as the longest wait rather than an undefined one.
  wire [2:0] code = (wait_sel_bits == 3'h7) ? 3'h6 : wait_sel_bits;  // [RL1]
  wire [cnt_width-1:0] target = cnt_width'(1) << (wait_min_exp + int'(code));  // [RL1]
  wire wait_done = (cnt_q == target - cnt_width'(1)) && (osc_running || !stop_pending_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      st_run: begin
        if (standby_enter) begin
          state_d = st_stdby;
        end else if (halt_exec) begin
          state_d = st_halt;  // [RL16]
        end
      end
      st_halt: begin
        if (release_ev) begin
          state_d = st_run;  // [RL18] [RL19]
        end
      end
      st_stdby: begin
        if (release_ev) begin
          state_d = (sel_stop || sel_idle2) ? st_wait : st_run;  // [RL3]
        end
      end
      st_wait: begin
        if (wait_done) begin
          state_d = st_run;  // [RL22]
        end
      end
      default: state_d = st_run;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || reset_source) begin
      state_q        <= st_run;  // [RL19]
      cnt_q          <= '0;
      stop_pending_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == st_stdby) begin
        cnt_q          <= '0;  // [RL22]
        stop_pending_q <= sel_stop;
      end else if (state_q == st_wait && (osc_running || !stop_pending_q)) begin
        cnt_q <= cnt_q + cnt_width'(1);  // [RL4] [RL22]
      end
    end
  end

  assign cpu_clk_en    = state_q == st_run;  // [RL16] [RL22]
  assign periph_clk_en = state_q != st_stdby && state_q != st_wait;  // [RL16]
  assign halted        = state_q == st_halt;
  assign waiting       = state_q == st_wait;
endmodule
`default_nettype wire

// ### hdl/standby_pkg.sv
// Package with register map, reset values and timing constants of the standby regulator control block.
package standby_pkg;
  localparam logic [31:0] regulator_low_voltage_select_addr = 32'hfffff332;
  localparam logic [11:0] reg_lvs_off   = 12'h332;
  localparam logic [11:0] reg_wait_off  = 12'h334;
  localparam logic [11:0] reg_guard_off = 12'h338;
  localparam logic [11:0] reg_mode_off  = 12'h33c;
  localparam logic [11:0] reg_stat_off  = 12'h340;
  localparam logic [7:0]  wait_sel_reset  = 8'h06;
  localparam logic [7:0]  guard_reset     = 8'h00;
  localparam logic [7:0]  lvs_reset       = 8'h00;
  localparam logic [7:0]  guard_enable    = 8'hc9;
  localparam logic [7:0]  mode_reset      = 8'h00;
  localparam int          wait_min_exp    = 10;
  localparam int          wait_max_exp    = 16;
  localparam int          wait_sel_width  = 3;
  localparam int          lvs_stop_bit    = 0;
  localparam int          lvs_sub_bit     = 1;
  localparam int          mode_trig_bit   = 2;
  localparam logic [1:0]  axi_okay        = 2'b00;
  localparam logic [1:0]  axi_slverr      = 2'b10;
  typedef enum logic [1:0] {
    st_run   = 2'b00,
    st_halt  = 2'b01,
    st_stdby = 2'b11,
    st_wait  = 2'b10
  } pwr_state_t;
endpackage

// ### verification/standby_regulator_control_checker.sv
// Checker of the standby regulator control ports.
`timescale 1ns/1ps
`default_nettype none
module standby_regulator_control_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       halt_exec,
  input wire logic       irq_pending,
  input wire logic       nmi_pin,
  input wire logic       watchdog_nonmaskable_irq,
  input wire logic       external_irq_pins,
  input wire logic       peripheral_irq,
  input wire logic       reset_source,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       low_voltage_stop_sel,
  input wire logic       low_voltage_subclock_sel,
  input wire logic       halted,
  input wire logic       waiting,
  input wire logic [2:0] wait_sel_bits
);
  logic [17:0] wcnt_q;
  logic        rel;
  assign rel = irq_pending | nmi_pin | watchdog_nonmaskable_irq | external_irq_pins | peripheral_irq | reset_source;
  // Counts cycles spent waiting so the shortest legal wait can be bounded from below.
  always_ff @(posedge aclk) begin
    if (!aresetn || !waiting) wcnt_q <= '0;
    else wcnt_q <= wcnt_q + 18'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst; $rose(aresetn) |-> wait_sel_bits == 3'h6 && !low_voltage_stop_sel && !low_voltage_subclock_sel; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_hin; !halted && !waiting && cpu_clk_en && halt_exec && !reset_source |=> halted; endproperty
  a_hin: assert property (p_hin) else $error("halt not entered");
  property p_hclk; halted |-> !cpu_clk_en && periph_clk_en; endproperty
  a_hclk: assert property (p_hclk) else $error("halt clock gating wrong");
  property p_hrel; halted && rel |=> !halted && cpu_clk_en; endproperty
  a_hrel: assert property (p_hrel) else $error("halt not released");
  property p_wgate; waiting |-> !cpu_clk_en && !halted; endproperty
  a_wgate: assert property (p_wgate) else $error("cpu clock during wait");
  property p_wlen; $fell(waiting) && !$past(reset_source) |-> wcnt_q >= 18'd1024; endproperty
  a_wlen: assert property (p_wlen) else $error("wait too short");
  property p_lvs; $changed({low_voltage_stop_sel, low_voltage_subclock_sel}) |-> $rose(s_axi_bvalid); endproperty
  a_lvs: assert property (p_lvs) else $error("regulator mode changed without write");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_bst; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bst: assert property (p_bst) else $error("write response dropped");
endmodule
bind standby_regulator_control standby_regulator_control_checker chk_i (.*);
`default_nettype wire

// ### verification/standby_regulator_control_tb.sv
// Testbench of the standby regulator control block.
`timescale 1ns/1ps
`default_nettype none
module standby_regulator_control_tb;
  import standby_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, halt_exec = 0, osc = 1;
  logic [31:0] awa = 0, wd = 0, ara = 0, rdata;
  logic [3:0] ws = 0;
  logic [5:0] src = 0;
  logic awr, wr_, bv, arr, rv, cen, pen, lstop, lsub, hlt, wtg;
  logic [1:0] br, rr;
  logic [2:0] wsb;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  standby_regulator_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .halt_exec(halt_exec), .irq_pending(src[0]), .nmi_pin(src[1]), .watchdog_nonmaskable_irq(src[2]),
    .external_irq_pins(src[3]), .peripheral_irq(src[4]), .reset_source(src[5]), .osc_running(osc),
    .cpu_clk_en(cen), .periph_clk_en(pen), .low_voltage_stop_sel(lstop), .low_voltage_subclock_sel(lsub),
    .halted(hlt), .waiting(wtg), .wait_sel_bits(wsb));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Handshakes are judged at the falling edge, acted on at the next rising edge.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic fa, fw, ta, tw, got;
    fa = 0; fw = 0; got = 0;
    awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; bready <= 1;
    while (!(fa && fw)) begin
      @(negedge aclk); ta = awv && awr; tw = wv && wr_;
      @(posedge aclk);
      if (ta) begin fa = 1; awv <= 0; end
      if (tw) begin fw = 1; wv <= 0; end
    end
    while (!got) begin
      @(negedge aclk); got = bv;
      if (got) chk("bresp", {30'h0, br}, {30'h0, er});
      @(posedge aclk);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic got;
    got = 0;
    ara <= a; arv <= 1; rready <= 1;
    do begin @(negedge aclk); got = arr; @(posedge aclk); end while (!got);
    arv <= 0; got = 0;
    while (!got) begin
      @(negedge aclk); got = rv;
      if (got) begin chk("rdata", rdata, e); chk("rresp", {30'h0, rr}, {30'h0, er}); end
      @(posedge aclk);
    end
  endtask
  // The wait is counted from the release; the oscillator is held off for stall cycles meanwhile.
  task automatic stby(input logic [2:0] m, input int stall, input int expw);
    int n;
    n = 0;
    wr(32'h33c, {29'h0, m}, 4'hf, axi_okay);
    @(negedge aclk);
    while (pen && n < 20) begin @(negedge aclk); n++; end
    chk("standby entered", {31'h0, pen}, 32'h0);
    @(posedge aclk);
    osc <= (stall == 0);
    src[0] <= 1;
    @(posedge aclk);
    src[0] <= 0;
    n = 0;
    @(negedge aclk);
    chk("waiting", {31'h0, wtg}, {31'h0, expw != 0});
    while (!cen && n < 5000) begin
      @(posedge aclk);
      n++;
      if (n == stall) osc <= 1;
      @(negedge aclk);
    end
    chk("wait cycles", {31'h0, n >= expw && n <= expw + 3}, 32'h1);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin n_mismatch++; end_sim(); end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(32'h334, 32'h6, axi_okay);
    rd(32'h338, 32'h0, axi_okay);
    rd(32'h330, 32'h0, axi_okay);
    rd(32'h3f0, 32'h0, axi_slverr);
    rd(32'h340, 32'h1, axi_okay);
    wr(32'h330, 32'h10000, 4'h4, axi_okay);
    rd(32'h330, 32'h0, axi_okay);
    wr(32'h338, 32'hc9, 4'hf, axi_okay);
    wr(32'h330, 32'h10000, 4'h4, axi_okay);
    rd(32'h330, 32'h10000, axi_okay);
    chk("stop sel", {30'h0, lsub, lstop}, 32'h1);
    osc <= 0;
    wr(32'h330, 32'h20000, 4'hf, axi_slverr);
    wr(32'h330, 32'h20000, 4'h4, axi_okay);
    chk("sub sel", {30'h0, lsub, lstop}, 32'h2);
    osc <= 1;
    wr(32'h338, 32'h55, 4'hf, axi_okay);
    wr(32'h330, 32'h0, 4'h4, axi_okay);
    chk("odd guard", {30'h0, lsub, lstop}, 32'h2);
    wr(32'h338, 32'h0, 4'hf, axi_okay);
    wr(32'h334, 32'h0, 4'h1, axi_slverr);
    wr(32'h334, 32'h0, 4'hf, axi_okay);
    chk("wait sel", {29'h0, wsb}, 32'h0);
    for (int k = 0; k < 6; k++) begin
      halt_exec <= 1; @(posedge aclk); halt_exec <= 0;
      @(negedge aclk);
      chk("halt clocks", {29'h0, hlt, cen, pen}, 32'h5);
      @(posedge aclk); src <= 6'h1 << k; @(posedge aclk); src <= 0;
      @(negedge aclk);
      chk("halt release", {30'h0, hlt, cen}, 32'h1);
      @(posedge aclk);
    end
    src[0] <= 1; halt_exec <= 1; @(posedge aclk); halt_exec <= 0;
    @(negedge aclk); chk("pending halt", {31'h0, hlt}, 32'h1);
    @(posedge aclk); src[0] <= 0;
    @(negedge aclk); chk("pending exit", {31'h0, hlt}, 32'h0);
    @(posedge aclk);
    stby(3'b101, 40, 1064);
    stby(3'b111, 0, 1024);
    stby(3'b110, 40, 1024);
    rd(32'h33c, 32'h2, axi_okay);
    stby(3'b100, 0, 0);
    end_sim();
  end
endmodule
`default_nettype wire
